// ===== design/dps_pkg.sv
// Shared constants and types for the display power-save controller.
package dps_pkg;

    // Register indices; byte address on the bus is four times the index.
    localparam logic [8:0] IDX_REFRESH_SEL  = 9'h021;  // Refresh select.
    localparam logic [8:0] IDX_CLOCK_CFG    = 9'h018;  // Clock configuration.
    localparam logic [8:0] IDX_PS_CONTROL   = 9'h1f0;  // Power-save control.
    localparam logic [8:0] IDX_PS_STATUS    = 9'h1f1;  // Power-save status.
    localparam logic [8:0] IDX_DISPLAY_MODE = 9'h1fc;  // Display mode select.

    // Field positions.
    localparam int PS_ENABLE_BIT     = 0;  // Power-save request.
    localparam int ST_LCD_DOWN_BIT   = 1 - 1;  // LCD fully powered down.
    localparam int ST_DRAM_DOWN_BIT  = 1;  // DRAM interface powered down.
    localparam int DM_LCD_BIT        = 0;  // LCD enable.
    localparam int DM_CRT_BIT        = 1;  // CRT enable.
    localparam int DM_TV_BIT         = 2;  // TV enable.
    localparam int RS_MODE_LSB       = 6;  // Refresh mode field, bits 7-6.
    localparam int CC_DOUBLER_BIT    = 7;  // Pixel clock doubler enable.

    // Reset values of the writable registers.
    localparam logic [7:0] RST_PS_CONTROL   = 8'h00;
    localparam logic [7:0] RST_DISPLAY_MODE = 8'h00;
    localparam logic [7:0] RST_REFRESH_SEL  = 8'h00;
    localparam logic [7:0] RST_CLOCK_CFG    = 8'h00;

    // Refresh methods used while in power save.
    typedef enum logic [1:0] {
        REF_CBR  = 2'b00,
        REF_SELF = 2'b01,
        REF_NONE = 2'b10,
        REF_NONE_ALT = 2'b11
    } refresh_mode_t;

    // Command level presented to the DRAM controller.
    typedef enum logic [1:0] {
        DRAM_IDLE = 2'b00,
        DRAM_CBR  = 2'b01,
        DRAM_SELF = 2'b10
    } dram_cmd_t;

    // Timing, in nanoseconds and in 8 ns clock cycles.
    localparam int CLK_PERIOD_NS  = 8;
    localparam int LCD_STEP_NS    = 1000;   // Least time per panel power step.
    localparam int DRAM_QUIET_NS  = 128;    // Least quiet time before power-down.
    localparam int CBR_PERIOD_NS  = 15600;  // Longest time between CBR refreshes.
    localparam int LCD_STEP_CYCLES  = (LCD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DRAM_QUIET_CYCLES = (DRAM_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CBR_CYCLES       = CBR_PERIOD_NS / CLK_PERIOD_NS;

endpackage : dps_pkg

// ===== design/lcd_power_seq.sv
// Panel power sequencer for the LCD path.
`timescale 1ns/1ps
module lcd_power_seq (
    input  wire logic clk_i,          // Core clock.
    input  wire logic rst_i,          // Synchronous reset, active high.
    input  wire logic want_on_i,      // Panel is wanted on.
    output logic      panel_power_o,  // Panel supply enable.
    output logic      signals_on_o,   // Panel signals may be driven.
    output logic      down_o          // Panel fully powered down.
);
    import dps_pkg::*;

    typedef enum logic [1:0] {
        S_OFF  = 2'b00,
        S_UP   = 2'b01,
        S_ON   = 2'b10,
        S_DOWN = 2'b11
    } lcd_state_t;

    lcd_state_t state;        // Sequencer state.
    logic [11:0] step_count;  // Time spent in a transition.
    logic        step_done;   // Transition time has elapsed.

    assign step_done = (step_count == 12'(LCD_STEP_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // A transition always completes before reversing, so the panel never sees
    // a shortened power step.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state      <= S_OFF;
            step_count <= 12'h0000;
        end else begin
            case (state)
                S_OFF: begin
                    step_count <= 12'h0000;
                    if (want_on_i) begin
                        state <= S_UP;
                    end
                end
                S_UP, S_DOWN: begin
                    if (step_done) begin
                        step_count <= 12'h0000;
                        state      <= (state == S_UP) ? S_ON : S_OFF;
                    end else begin
                        step_count <= step_count + 12'h0001;
                    end
                end
                default: begin
                    step_count <= 12'h0000;
                    if (!want_on_i) begin
                        state <= S_DOWN;
                    end
                end
            endcase
        end
    end

    // Power comes first on the way up and goes last on the way down.
    assign panel_power_o = (state != S_OFF);
    assign signals_on_o  = (state == S_ON);
    assign down_o        = (state == S_OFF);

endmodule : lcd_power_seq

// ===== design/dram_arbiter.sv
// Display memory arbiter and refresh control.
`timescale 1ns/1ps
module dram_arbiter (
    input  wire logic                  clk_i,        // Core clock.
    input  wire logic                  rst_i,        // Synchronous reset.
    input  wire logic                  ps_i,         // Power save active.
    input  wire dps_pkg::refresh_mode_t mode_i,      // Refresh method in power save.
    input  wire logic                  scr_req_i,    // Screen refresh fetch request.
    input  wire logic                  host_req_i,   // Host memory request.
    output logic                       scr_gnt_o,    // Screen fetch granted.
    output logic                       host_gnt_o,   // Host access granted.
    output logic                       refuse_o,     // Host access refused.
    output dps_pkg::dram_cmd_t         cmd_o,        // Refresh command level.
    output logic                       down_o        // DRAM interface powered down.
);
    import dps_pkg::*;

    logic [11:0] cbr_count;   // Time since last refresh tick.
    logic        cbr_pend;    // A CBR refresh is owed.
    logic        cbr_issue;   // CBR refresh issued this cycle.
    logic [4:0]  quiet_count; // Quiet cycles since power save began.
    logic        use_cbr;     // CBR refresh runs in the current state.

    assign use_cbr = !ps_i || (mode_i == REF_CBR);

    ////////////////////////////////////////////////////////////////////////////
    // Screen fetch first, then owed refresh, host only on leftover cycles.
    assign scr_gnt_o  = scr_req_i && !ps_i;
    assign cbr_issue  = cbr_pend && !scr_gnt_o;
    assign host_gnt_o = host_req_i && !ps_i && !scr_req_i && !cbr_pend;
    assign refuse_o   = host_req_i && ps_i;

    // Refresh tick; a new tick wins over the clear by an issue.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cbr_count <= 12'h0000;
            cbr_pend  <= 1'b0;
        end else if (!use_cbr) begin
            cbr_count <= 12'h0000;
            cbr_pend  <= 1'b0;
        end else if (cbr_count == 12'(CBR_CYCLES - 1)) begin
            cbr_count <= 12'h0000;
            cbr_pend  <= 1'b1;
        end else begin
            cbr_count <= cbr_count + 12'h0001;
            cbr_pend  <= cbr_pend && !cbr_issue;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-down follows a short quiet time, never under CBR refresh.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quiet_count <= 5'h00;
            down_o      <= 1'b0;
        end else if (use_cbr) begin
            quiet_count <= 5'h00;
            down_o      <= 1'b0;
        end else if (quiet_count == 5'(DRAM_QUIET_CYCLES - 1)) begin
            down_o      <= 1'b1;
        end else begin
            quiet_count <= quiet_count + 5'h01;
        end
    end

    // Command level: CBR pulse, held self-refresh, or nothing at all.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_o <= DRAM_IDLE;
        end else if (cbr_issue && use_cbr) begin
            cmd_o <= DRAM_CBR;
        end else if (ps_i && mode_i == REF_SELF && down_o) begin
            cmd_o <= DRAM_SELF;
        end else begin
            cmd_o <= DRAM_IDLE;
        end
    end

endmodule : dram_arbiter

// ===== design/display_power_save_control.sv
// Power-save and display-enable controller with its Wishbone register file.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - Both displays stay off after reset.
// - Display mode bits enable each display separately.
// - Power-save bit drops CRT, sequences LCD down.
// - Power save refuses memory access, refresh only.
// - Registers stay accessible during power save.
// - LCD status bit set only when fully down.
// - DRAM status set under self/no refresh only.
// - Power-save refresh is CBR, self, or none.
// - LCD lookup table needs LCD pixel clock.
// - CRT lookup table needs CRT pixel clock.
// - Bit 7 enables the pixel clock doubler while CRT/TV runs.
// - Idle functions get their clocks gated.
// - Unused display pipelines are shut down.
// - Screen refresh beats host in arbitration.
module display_power_save_control (
    input  wire logic               CORE_CLK_I,        // Core clock, 125 MHz.
    input  wire logic               RST_I,             // Synchronous reset, active high.
    input  wire logic [10:0]        ADR_I,             // Wishbone byte address.
    input  wire logic [31:0]        DAT_I,             // Wishbone write data.
    output logic      [31:0]        DAT_O,             // Wishbone read data.
    input  wire logic               WE_I,              // Wishbone write enable.
    input  wire logic [3:0]         SEL_I,             // Wishbone byte selects.
    input  wire logic               CYC_I,             // Wishbone cycle.
    input  wire logic               STB_I,             // Wishbone strobe.
    output logic                    ACK_O,             // Wishbone acknowledge.
    input  wire logic [15:0]        LCD_PIX_I,         // Pixels from LCD pipeline.
    output logic      [15:0]        LCD_PIX_O,         // Pixels to the panel.
    output logic                    LCD_PWR_O,         // Panel supply enable.
    output logic                    CRT_DAC_EN_O,      // CRT/TV output current enable.
    output logic                    LCD_PIPE_EN_O,     // LCD pipeline run enable.
    output logic                    CRT_PIPE_EN_O,     // CRT/TV pipeline run enable.
    input  wire logic               LCD_LUT_REQ_I,     // Host LCD lookup table access.
    input  wire logic               CRT_LUT_REQ_I,     // Host CRT lookup table access.
    output logic                    LCD_CLK_EN_O,      // LCD pixel clock gate.
    output logic                    CRT_CLK_EN_O,      // CRT/TV pixel clock gate.
    output logic                    MEM_CLK_EN_O,      // Memory clock gate.
    output logic                    DOUBLER_EN_O,      // Pixel clock doubler enable.
    input  wire logic               SCR_REQ_I,         // Screen refresh fetch request.
    output logic                    SCR_GNT_O,         // Screen refresh fetch grant.
    input  wire logic               HOST_MEM_REQ_I,    // Host display memory request.
    output logic                    HOST_MEM_GNT_O,    // Host display memory grant.
    output logic                    HOST_MEM_REFUSE_O, // Host memory access refused.
    output dps_pkg::dram_cmd_t      DRAM_CMD_O         // Refresh command level.
);
    import dps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [7:0] ps_control;    // Power-save control.
    logic [7:0] display_mode;  // Display mode select.
    logic [7:0] refresh_sel;   // Refresh select.
    logic [7:0] clock_cfg;     // Clock configuration.
    logic [7:0] ps_status;     // Power-save status, built from live state.

    logic       ps_active;     // Power save requested.
    logic       lcd_want;      // LCD should be up.
    logic       crt_want;      // CRT/TV should be running.
    logic       lcd_down;      // Panel is fully powered down.
    logic       lcd_live;      // Panel signals may be driven.
    logic       dram_down;     // DRAM interface is powered down.
    logic       bus_req;       // Wishbone request is present.
    logic       wr_strobe;     // Write takes effect this edge.
    logic [8:0] reg_index;     // Register index from the byte address.

    assign bus_req   = CYC_I && STB_I;
    assign reg_index = ADR_I[10:2];

    // A write lands on the edge where the master sees ACK high.
    assign wr_strobe = bus_req && ACK_O && WE_I && SEL_I[0];

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone acknowledge: one wait state, dropped the cycle after.
    // Unmapped indices are still acknowledged and read as zero so that a
    // stray access never hangs the bus.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= bus_req && !ACK_O;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data is captured when the request is first seen and then held.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            DAT_O <= 32'h0000_0000;
        end else if (bus_req && !ACK_O && !WE_I) begin
            if (reg_index == IDX_PS_CONTROL) begin
                DAT_O <= {24'h00_0000, ps_control};
            end else if (reg_index == IDX_PS_STATUS) begin
                DAT_O <= {24'h00_0000, ps_status};
            end else if (reg_index == IDX_DISPLAY_MODE) begin
                DAT_O <= {24'h00_0000, display_mode};
            end else if (reg_index == IDX_REFRESH_SEL) begin
                DAT_O <= {24'h00_0000, refresh_sel};
            end else if (reg_index == IDX_CLOCK_CFG) begin
                DAT_O <= {24'h00_0000, clock_cfg};
            end else begin
                DAT_O <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Writable registers. They run on the core clock alone, so they stay
    // reachable in power save while the memory clock may be stopped.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            ps_control   <= RST_PS_CONTROL;
            display_mode <= RST_DISPLAY_MODE;
            refresh_sel  <= RST_REFRESH_SEL;
            clock_cfg    <= RST_CLOCK_CFG;
        end else if (wr_strobe) begin
            // Only the documented fields are kept; other bits read as zero.
            if (reg_index == IDX_PS_CONTROL) begin
                ps_control <= {7'h00, DAT_I[PS_ENABLE_BIT]};
            end else if (reg_index == IDX_DISPLAY_MODE) begin
                display_mode <= {5'h00, DAT_I[2:0]};
            end else if (reg_index == IDX_REFRESH_SEL) begin
                refresh_sel <= {DAT_I[RS_MODE_LSB+1:RS_MODE_LSB], 6'h00};
            end else if (reg_index == IDX_CLOCK_CFG) begin
                clock_cfg <= {DAT_I[CC_DOUBLER_BIT], 7'h00};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Display enables. Power save overrides the mode bits without changing
    // them, so leaving power save brings back what was enabled before.
    assign ps_active = ps_control[PS_ENABLE_BIT];
    assign lcd_want  = display_mode[DM_LCD_BIT] && !ps_active;
    assign crt_want  = (display_mode[DM_CRT_BIT] || display_mode[DM_TV_BIT])
                       && !ps_active;

    // Panel power sequencing for the LCD path.
    lcd_power_seq u_lcd_seq (
        .clk_i         (CORE_CLK_I),
        .rst_i         (RST_I),
        .want_on_i     (lcd_want),
        .panel_power_o (LCD_PWR_O),
        .signals_on_o  (lcd_live),
        .down_o        (lcd_down)
    );

    // Memory arbitration and power-save refresh.
    dram_arbiter u_arb (
        .clk_i      (CORE_CLK_I),
        .rst_i      (RST_I),
        .ps_i       (ps_active),
        .mode_i     (refresh_mode_t'(refresh_sel[RS_MODE_LSB+1:RS_MODE_LSB])),
        .scr_req_i  (SCR_REQ_I),
        .host_req_i (HOST_MEM_REQ_I),
        .scr_gnt_o  (SCR_GNT_O),
        .host_gnt_o (HOST_MEM_GNT_O),
        .refuse_o   (HOST_MEM_REFUSE_O),
        .cmd_o      (DRAM_CMD_O),
        .down_o     (dram_down)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status register from live state; bits other than 1-0 read zero.
    always_comb begin
        ps_status                   = 8'h00;
        ps_status[ST_LCD_DOWN_BIT]  = lcd_down;
        ps_status[ST_DRAM_DOWN_BIT] = dram_down;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output stage. Panel pixels are forced low unless the panel is live, and
    // the CRT/TV current source follows its enable with no sequencing.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            LCD_PIX_O    <= 16'h0000;
            CRT_DAC_EN_O <= 1'b0;
        end else begin
            LCD_PIX_O    <= lcd_live ? LCD_PIX_I : 16'h0000;
            CRT_DAC_EN_O <= crt_want;
        end
    end

    // Pipelines run only when their display is in use.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            LCD_PIPE_EN_O <= 1'b0;
            CRT_PIPE_EN_O <= 1'b0;
        end else begin
            LCD_PIPE_EN_O <= lcd_live;
            CRT_PIPE_EN_O <= crt_want;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock gating. A pixel clock is also kept while its lookup table is
    // being accessed, so the table works with its display off. The trade-off
    // is a little power burnt during table updates in power save.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            LCD_CLK_EN_O <= 1'b0;
            CRT_CLK_EN_O <= 1'b0;
            MEM_CLK_EN_O <= 1'b1;
            DOUBLER_EN_O <= 1'b0;
        end else begin
            LCD_CLK_EN_O <= LCD_PWR_O || LCD_LUT_REQ_I;
            CRT_CLK_EN_O <= crt_want || CRT_LUT_REQ_I;
            MEM_CLK_EN_O <= !dram_down;
            DOUBLER_EN_O <= clock_cfg[CC_DOUBLER_BIT] && crt_want;
        end
    end

endmodule : display_power_save_control

// ===== tb/dps_checker_sva.sv
// Port-level assertions for the display power-save controller.
`timescale 1ns/1ps
module dps_checker (
    input wire logic               CORE_CLK_I,        // Clock.
    input wire logic               RST_I,             // Reset.
    input wire logic               CYC_I,             // Cycle.
    input wire logic               STB_I,             // Strobe.
    input wire logic               ACK_O,             // Acknowledge.
    input wire logic [15:0]        LCD_PIX_O,         // Panel pixels.
    input wire logic               LCD_PWR_O,         // Panel supply.
    input wire logic               LCD_PIPE_EN_O,     // LCD pipeline.
    input wire logic               CRT_DAC_EN_O,      // CRT current.
    input wire logic               SCR_REQ_I,         // Screen fetch.
    input wire logic               SCR_GNT_O,         // Screen grant.
    input wire logic               HOST_MEM_REQ_I,    // Host request.
    input wire logic               HOST_MEM_GNT_O,    // Host grant.
    input wire logic               HOST_MEM_REFUSE_O, // Host refused.
    input wire dps_pkg::dram_cmd_t DRAM_CMD_O         // Refresh command.
);
    import dps_pkg::*;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    ////////////////////////////////////////////////////////////////
    // A taken request must be answered by a one-cycle acknowledge.
    sequence s_take; CYC_I && STB_I && !ACK_O; endsequence
    sequence s_ack_pulse; ACK_O ##1 !ACK_O; endsequence
    property p_ack; s_take |=> s_ack_pulse; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_reset_off; $fell(RST_I) |-> !CRT_DAC_EN_O && !LCD_PWR_O && !LCD_PIPE_EN_O; endproperty
    a_reset_off: assert property (p_reset_off) else $error("display live after reset");
    property p_refuse_nogrant; HOST_MEM_REFUSE_O |-> !HOST_MEM_GNT_O; endproperty
    a_refuse_nogrant: assert property (p_refuse_nogrant) else $error("refused yet granted");
    property p_refuse_req; !HOST_MEM_REQ_I |-> !HOST_MEM_REFUSE_O; endproperty
    a_refuse_req: assert property (p_refuse_req) else $error("refuse without request");
    // A panel without supply must see no driven pixel lines.
    property p_lcd_low; !LCD_PWR_O |-> LCD_PIX_O == 16'h0000; endproperty
    a_lcd_low: assert property (p_lcd_low) else $error("pixels driven while unpowered");
    property p_pipe_pwr; LCD_PIPE_EN_O |-> LCD_PWR_O; endproperty
    a_pipe_pwr: assert property (p_pipe_pwr) else $error("pipeline on without supply");
    property p_scr_first; SCR_REQ_I && HOST_MEM_REQ_I |-> !HOST_MEM_GNT_O && SCR_GNT_O == !HOST_MEM_REFUSE_O;
    endproperty
    a_scr_first: assert property (p_scr_first) else $error("host beat screen fetch");
    property p_cbr_pulse; DRAM_CMD_O == DRAM_CBR |=> DRAM_CMD_O != DRAM_CBR; endproperty
    a_cbr_pulse: assert property (p_cbr_pulse) else $error("refresh pulse too long");
endmodule : dps_checker
bind display_power_save_control dps_checker u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .LCD_PIX_O(LCD_PIX_O), .LCD_PWR_O(LCD_PWR_O),
    .LCD_PIPE_EN_O(LCD_PIPE_EN_O), .CRT_DAC_EN_O(CRT_DAC_EN_O), .SCR_REQ_I(SCR_REQ_I),
    .SCR_GNT_O(SCR_GNT_O), .HOST_MEM_REQ_I(HOST_MEM_REQ_I), .HOST_MEM_GNT_O(HOST_MEM_GNT_O),
    .HOST_MEM_REFUSE_O(HOST_MEM_REFUSE_O), .DRAM_CMD_O(DRAM_CMD_O));

// ===== tb/host_model.sv
// Host processor model: a classic Wishbone master for register access.
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_i, // Core clock.
    input  wire logic        ack_i, // Slave acknowledge.
    input  wire logic [31:0] dat_i, // Read data.
    output logic             cyc_o, // Cycle.
    output logic             stb_o, // Strobe.
    output logic             we_o,  // Write enable.
    output logic [10:0]      adr_o, // Byte address.
    output logic [31:0]      dat_o, // Write data.
    output logic [3:0]       sel_o  // Byte selects.
);
    initial begin
        cyc_o <= 1'b0; stb_o <= 1'b0; we_o <= 1'b0;
        adr_o <= 11'h000; dat_o <= 32'h0000_0000; sel_o <= 4'h0;
    end
    // One transfer; called just after a rising edge, holds until ack.
    // Only the bench's own timeout ends a wait for a silent slave.
    task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d, output logic [31:0] q);
        cyc_o <= 1'b1; stb_o <= 1'b1; we_o <= w;
        adr_o <= a; dat_o <= {24'h00_0000, d}; sel_o <= 4'h1;
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0; stb_o <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
endmodule : host_model

// ===== tb/tb.sv
// Self-checking testbench for the display power-save controller.
`timescale 1ns/1ps
module tb;
    import dps_pkg::*;
    localparam logic [10:0] REFS = 11'h084, CCFG = 11'h060, PSC = 11'h7c0, PSS = 11'h7c4, MODE = 11'h7f0;
    logic clk, rst, cyc, stb, we, ack, scr_req, scr_gnt, host_req, lut;
    logic [10:0] adr;
    logic [31:0] wdat, rdat;
    logic [3:0]  sel;
    logic [15:0] pix;
    int errors = 0, tests_run = 0, cycles = 0;
    display_power_save_control DUT (.CORE_CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(wdat),
        .DAT_O(rdat), .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
        .LCD_PIX_I(pix), .LCD_PIX_O(), .LCD_PWR_O(), .CRT_DAC_EN_O(), .LCD_PIPE_EN_O(),
        .CRT_PIPE_EN_O(), .LCD_LUT_REQ_I(lut), .CRT_LUT_REQ_I(lut), .LCD_CLK_EN_O(),
        .CRT_CLK_EN_O(), .MEM_CLK_EN_O(), .DOUBLER_EN_O(), .SCR_REQ_I(scr_req), .SCR_GNT_O(scr_gnt),
        .HOST_MEM_REQ_I(host_req), .HOST_MEM_GNT_O(), .HOST_MEM_REFUSE_O(), .DRAM_CMD_O());
    host_model host (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .dat_o(wdat), .sel_o(sel));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole run needs about 2300 cycles; the ceiling leaves ample margin.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n); repeat (n) @(posedge clk); endtask : tick
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [10:0] a, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask : rd
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(DUT.CRT_DAC_EN_O, 0);
        rd(PSS, 32'h0000_0001);
        rd(MODE, 32'h0000_0000);
        rd(11'h100, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_crt();
        logic [7:0] m[3] = '{8'h02, 8'h04, 8'h00};
        foreach (m[i]) begin
            wr(MODE, m[i]);
            tick(2);
            chk(DUT.CRT_DAC_EN_O, m[i] != 8'h00);
            chk(DUT.CRT_PIPE_EN_O, m[i] != 8'h00);
            chk(DUT.LCD_PWR_O, 0);
        end
        wr(MODE, 8'h02);
        wr(CCFG, 8'h80);
        tick(2);
        chk(DUT.DOUBLER_EN_O, 1);
        rd(CCFG, 32'h0000_0080);
        $display("test crt done");
    endtask : t_crt
    // CBR refresh in power save: the DRAM status must never set.
    task automatic t_cbr();
        int n;
        wr(PSC, 8'h01);
        tick(2);
        chk(DUT.CRT_DAC_EN_O, 0);
        tick(40);
        rd(PSS, 32'h0000_0001);
        n = 0;
        while (DUT.DRAM_CMD_O !== DRAM_CBR && n < 2500) begin
            @(posedge clk);
            n++;
        end
        chk(n < 2500, 1);
        wr(PSC, 8'h00);
        tick(2);
        chk(DUT.CRT_DAC_EN_O, 1);
        $display("test cbr done");
    endtask : t_cbr
    task automatic t_lcd();
        pix <= 16'ha5c3;
        wr(MODE, 8'h03);
        rd(PSS, 32'h0000_0000);
        chk(DUT.LCD_PIPE_EN_O, 0);
        tick(135);
        chk(DUT.LCD_PIPE_EN_O, 1);
        chk(DUT.LCD_PIX_O, 16'ha5c3);
        $display("test lcd done");
    endtask : t_lcd
    task automatic t_self();
        wr(REFS, 8'h40);
        wr(PSC, 8'h01);
        host_req <= 1'b1;
        tick(2);
        chk(DUT.HOST_MEM_REFUSE_O, 1);
        chk(DUT.HOST_MEM_GNT_O, 0);
        chk(DUT.CRT_DAC_EN_O, 0);
        rd(MODE, 32'h0000_0003);
        tick(140);
        chk(DUT.LCD_PWR_O, 0);
        chk(DUT.LCD_PIX_O, 0);
        chk(DUT.DRAM_CMD_O, DRAM_SELF);
        chk(DUT.MEM_CLK_EN_O, 0);
        chk(DUT.LCD_CLK_EN_O, 0);
        lut <= 1'b1;
        tick(2);
        chk(DUT.LCD_CLK_EN_O, 1);
        chk(DUT.CRT_CLK_EN_O, 1);
        lut <= 1'b0;
        rd(PSS, 32'h0000_0003);
        wr(PSC, 8'h00);
        tick(2);
        chk(DUT.HOST_MEM_REFUSE_O, 0);
        chk(DUT.MEM_CLK_EN_O, 1);
        chk(DUT.CRT_DAC_EN_O, 1);
        rd(PSS, 32'h0000_0000);
        $display("test self refresh done");
    endtask : t_self
    task automatic t_arb();
        int n;
        scr_req <= 1'b1;
        tick(2);
        chk(scr_gnt, 1);
        chk(DUT.HOST_MEM_GNT_O, 0);
        scr_req <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (DUT.HOST_MEM_GNT_O !== 1'b1 && n < 8);
        chk(n < 8, 1);
        host_req <= 1'b0;
        $display("test arbitration done");
    endtask : t_arb
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        rst = 1'b1; scr_req = 1'b0; host_req = 1'b0; pix = 16'h0000;
        lut = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset(); t_crt(); t_cbr(); t_lcd(); t_self(); t_arb();
        wrap_up();
    end
endmodule : tb
